//--- pkg/rcdl_pkg.sv
// Package: register map, field layout, reset values and types of the radio cal/loop config bank
package rcdl_pkg;
  // Register byte addresses
  localparam logic [15:0] ADDR_CAL_POLICY = 16'hDF14;
  localparam logic [15:0] ADDR_FOC_CFG = 16'hDF15;
  localparam logic [15:0] ADDR_BS_CFG = 16'hDF16;
  // Reset values
  localparam logic [7:0] RST_CAL_POLICY = 8'h04;
  localparam logic [7:0] RST_FOC_CFG = 8'h76;
  localparam logic [7:0] RST_BS_CFG = 8'h6C;
  // Writable bit masks; unused upper bits read zero
  localparam logic [7:0] MASK_CAL_POLICY = 8'h3F;
  localparam logic [7:0] MASK_FOC_CFG = 8'h7F;
  localparam logic [7:0] MASK_BS_CFG = 8'hFF;
  // Field positions
  localparam int CAL_MODE_LSB = 4;
  localparam int GATE_BIT = 5;
  localparam int FOC_PRE_LSB = 3;
  localparam int FOC_POST_BIT = 2;
  localparam int FOC_LIM_LSB = 0;
  localparam int KI_PRE_LSB = 6;
  localparam int KP_PRE_LSB = 4;
  localparam int KI_POST_BIT = 3;
  localparam int KP_POST_BIT = 2;
  localparam int RATE_LIM_LSB = 0;
  // Return counter wrap value for every-fourth mode
  localparam logic [1:0] RETURN_WRAP = 2'h3;

  // Calibration policy modes
  typedef enum logic [1:0] {
    CAL_NEVER = 2'h0,
    CAL_ON_START = 2'h1,
    CAL_ON_RETURN = 2'h2,
    CAL_EVERY_FOURTH = 2'h3
  } rcdl_cal_mode_e;

  // Register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rcdl_bus_s;

  // Radio state-machine events
  typedef struct packed {
    logic idle_to_active;
    logic auto_return_idle;
    logic manual_cal;
  } rcdl_radio_ev_s;

  // Loop gain selections to the demodulator; gains in halves of the base gain
  typedef struct packed {
    logic freeze;
    logic [3:0] foc_gain_half;
    logic [1:0] freq_offset_saturation;
    logic [3:0] ki_gain_half;
    logic [3:0] kp_gain_half;
    logic [1:0] rate_limit;
  } rcdl_loop_s;
endpackage

//--- verilog/rcdl_cal_ctrl.sv
// Calibration trigger decision from the calibration mode and radio events
`timescale 1ns/100ps
`default_nettype none
module rcdl_cal_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire rcdl_pkg::rcdl_radio_ev_s ev_i,
  output logic cal_o,
  output logic [1:0] count_o
);
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic cal_reg;
  logic cal_next;

  // Next-state decision for trigger and return counter
  always_comb begin
    cnt_next = cnt_reg;
    cal_next = ev_i.manual_cal;
    case (rcdl_pkg::rcdl_cal_mode_e'(mode_i))
      // [RL1] Manual strobe only
      rcdl_pkg::CAL_NEVER: begin
        cal_next = ev_i.manual_cal;
      end
      // [RL2] Calibrate on start
      rcdl_pkg::CAL_ON_START: begin
        cal_next = ev_i.manual_cal | ev_i.idle_to_active;
      end
      // [RL3] Calibrate on return
      rcdl_pkg::CAL_ON_RETURN: begin
        cal_next = ev_i.manual_cal | ev_i.auto_return_idle;
      end
      // [RL4] Every fourth return
      rcdl_pkg::CAL_EVERY_FOURTH: begin
        if (ev_i.auto_return_idle) begin
          cnt_next = cnt_reg + 2'h1;
          cal_next = ev_i.manual_cal | (cnt_reg == rcdl_pkg::RETURN_WRAP);
        end
      end
      default: begin
        cal_next = ev_i.manual_cal;
      end
    endcase
  end

  // Register trigger and counter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 2'h0;
      cal_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      cal_reg <= cal_next;
    end
  end

  assign cal_o = cal_reg;
  assign count_o = cnt_reg;

  // [RL4] Fourth return fires
  property p_fourth_return;
    @(posedge clk_i) disable iff (rst_i)
      (mode_i == 2'h3 && ev_i.auto_return_idle && cnt_reg == 2'h3) |=> cal_reg;
  endproperty
  a_fourth_return: assert property (p_fourth_return) else $error("fourth return missed"); // [RL4]

  // [RL1] No auto calibration
  property p_never_auto;
    @(posedge clk_i) disable iff (rst_i)
      (mode_i == 2'h0 && !ev_i.manual_cal) |=> !cal_reg;
  endproperty
  a_never_auto: assert property (p_never_auto) else $error("auto cal in never mode"); // [RL1]
endmodule
`default_nettype wire

//--- verilog/rcdl_top.sv
// Top: calibration-policy and demodulator loop configuration register bank
//
// Functional notes
// [RL1] Mode 00: calibrate only on the manual calibrate strobe.
// [RL2] Mode 01: calibrate on each idle to receive, transmit or synth-on.
// [RL3] Mode 10: calibrate on each automatic return to idle.
// [RL4] Mode 11: calibrate on every fourth automatic return, modulo-four count.
// [RL5] Software writes reserved low nibble 0100; reset value is 0100.
// [RL6] Software writes zero to reserved bit 6; it resets to one.
// [RL7] Gate bit set: both loops frozen until carrier sense goes high.
// [RL8] Pre-sync frequency gain: 00 K, 01 2K, 10 3K, 11 4K.
// [RL9] Post-sync frequency gain: 0 keeps pre-sync, 1 gives K/2.
// [RL10] Frequency limit: 00 off, 01 BW/8, 10 BW/4, 11 BW/2.
// [RL11] Pre-sync integral gain: 00 Ki up to 11 4Ki.
// [RL12] Pre-sync proportional gain: 00 Kp up to 11 4Kp.
// [RL13] Post-sync integral gain: 0 keeps pre-sync, 1 gives Ki/2.
// [RL14] Post-sync proportional gain: 0 keeps pre-sync, 1 gives Kp.
// [RL15] Rate limit: 00 off, 01 3.125%, 10 6.25%, 11 12.5%.
// [RL16] Unused upper bits read zero and ignore writes.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module rcdl_top (
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [15:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic IDLE_TO_ACTIVE_I,
  input wire logic AUTO_RETURN_IDLE_I,
  input wire logic MANUAL_CALIBRATE_STROBE_I,
  input wire logic CARRIER_SENSE_I,
  input wire logic SYNC_FOUND_I,
  output logic CAL_START_O,
  output logic [1:0] RETURN_COUNT_O,
  output rcdl_pkg::rcdl_loop_s LOOP_CFG_O
);
  rcdl_pkg::rcdl_bus_s bus;
  rcdl_pkg::rcdl_radio_ev_s ev;
  logic [7:0] cal_reg;
  logic [7:0] cal_next;
  logic [7:0] foc_reg;
  logic [7:0] foc_next;
  logic [7:0] bs_reg;
  logic [7:0] bs_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic cs_meta_reg;
  logic cs_sync_reg;
  rcdl_pkg::rcdl_loop_s loop_reg;
  rcdl_pkg::rcdl_loop_s loop_next;
  logic cal_start;
  logic [1:0] ret_count;

  // Pre-sync gain in halves: code n gives (n+1) times base
  function automatic logic [3:0] pre_half(input logic [1:0] code);
    pre_half = {1'b0, code, 1'b0} + 4'h2;
  endfunction

  // Post-sync gain: keep pre-sync or use alternate value
  function automatic logic [3:0] post_half(input logic sel, input logic [1:0] code, input logic [3:0] alt);
    post_half = sel ? alt : pre_half(code);
  endfunction

  // Bus and event grouping
  assign bus = '{addr: REG_ADDR_I, wdata: REG_WDATA_I, wr: REG_WR_I, rd: REG_RD_I};
  assign ev = '{idle_to_active: IDLE_TO_ACTIVE_I, auto_return_idle: AUTO_RETURN_IDLE_I,
                manual_cal: MANUAL_CALIBRATE_STROBE_I};

  // Register write and read decode
  always_comb begin
    cal_next = cal_reg;
    foc_next = foc_reg;
    bs_next = bs_reg;
    rdata_next = 8'h00;
    // [RL16] Mask unused bits
    if (bus.wr) begin
      case (bus.addr)
        rcdl_pkg::ADDR_CAL_POLICY: cal_next = bus.wdata & rcdl_pkg::MASK_CAL_POLICY;
        rcdl_pkg::ADDR_FOC_CFG: foc_next = bus.wdata & rcdl_pkg::MASK_FOC_CFG;
        rcdl_pkg::ADDR_BS_CFG: bs_next = bus.wdata & rcdl_pkg::MASK_BS_CFG;
        default: cal_next = cal_reg;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        rcdl_pkg::ADDR_CAL_POLICY: rdata_next = cal_reg;
        rcdl_pkg::ADDR_FOC_CFG: rdata_next = foc_reg;
        rcdl_pkg::ADDR_BS_CFG: rdata_next = bs_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Register storage; reserved bits keep reset values until written
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cal_reg <= rcdl_pkg::RST_CAL_POLICY;
      foc_reg <= rcdl_pkg::RST_FOC_CFG;
      bs_reg <= rcdl_pkg::RST_BS_CFG;
      rdata_reg <= 8'h00;
    end else begin
      cal_reg <= cal_next;
      foc_reg <= foc_next;
      bs_reg <= bs_next;
      rdata_reg <= rdata_next;
    end
  end

  // Carrier sense synchroniser
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cs_meta_reg <= 1'b0;
      cs_sync_reg <= 1'b0;
    end else begin
      cs_meta_reg <= CARRIER_SENSE_I;
      cs_sync_reg <= cs_meta_reg;
    end
  end

  // Loop selections to the demodulator
  always_comb begin
    // [RL7] Freeze until carrier
    loop_next.freeze = foc_reg[rcdl_pkg::GATE_BIT] & ~cs_sync_reg;
    // [RL8] [RL9] Frequency gain select
    loop_next.foc_gain_half = SYNC_FOUND_I ?
      post_half(foc_reg[rcdl_pkg::FOC_POST_BIT], foc_reg[rcdl_pkg::FOC_PRE_LSB +: 2], 4'h1) :
      pre_half(foc_reg[rcdl_pkg::FOC_PRE_LSB +: 2]);
    // [RL10] Frequency limit select
    loop_next.freq_offset_saturation = foc_reg[rcdl_pkg::FOC_LIM_LSB +: 2];
    // [RL11] [RL13] Integral gain select
    loop_next.ki_gain_half = SYNC_FOUND_I ?
      post_half(bs_reg[rcdl_pkg::KI_POST_BIT], bs_reg[rcdl_pkg::KI_PRE_LSB +: 2], 4'h1) :
      pre_half(bs_reg[rcdl_pkg::KI_PRE_LSB +: 2]);
    // [RL12] [RL14] Proportional gain select
    loop_next.kp_gain_half = SYNC_FOUND_I ?
      post_half(bs_reg[rcdl_pkg::KP_POST_BIT], bs_reg[rcdl_pkg::KP_PRE_LSB +: 2], 4'h2) :
      pre_half(bs_reg[rcdl_pkg::KP_PRE_LSB +: 2]);
    // [RL15] Rate limit select
    loop_next.rate_limit = bs_reg[rcdl_pkg::RATE_LIM_LSB +: 2];
  end

  // Loop selection register
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      loop_reg <= '0;
    end else begin
      loop_reg <= loop_next;
    end
  end

  // Calibration trigger logic
  rcdl_cal_ctrl u_cal (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .mode_i(cal_reg[rcdl_pkg::CAL_MODE_LSB +: 2]),
    .ev_i(ev),
    .cal_o(cal_start),
    .count_o(ret_count)
  );

  assign REG_RDATA_O = rdata_reg;
  assign CAL_START_O = cal_start;
  assign RETURN_COUNT_O = ret_count;
  assign LOOP_CFG_O = loop_reg;

  // [RL16] Upper bits stay zero
  property p_upper_zero;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (REG_RD_I && REG_ADDR_I == 16'hDF14) |=> REG_RDATA_O[7:6] == 2'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused bits read nonzero"); // [RL16]

  // [RL7] Frozen while gated
  property p_freeze;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (!SYS_RST_I && foc_reg[rcdl_pkg::GATE_BIT] && !cs_sync_reg) |=> LOOP_CFG_O.freeze;
  endproperty
  a_freeze: assert property (p_freeze) else $error("loops not frozen"); // [RL7]

  // [RL2] Start calibration
  property p_start_cal;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (cal_reg[5:4] == 2'h1 && IDLE_TO_ACTIVE_I) |=> CAL_START_O;
  endproperty
  a_start_cal: assert property (p_start_cal) else $error("start cal missed"); // [RL2]

  // [RL3] Return calibration
  property p_return_cal;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (cal_reg[5:4] == 2'h2 && AUTO_RETURN_IDLE_I) |=> CAL_START_O;
  endproperty
  a_return_cal: assert property (p_return_cal) else $error("return cal missed"); // [RL3]

  // [RL9] Post-sync half gain
  property p_foc_post;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (SYNC_FOUND_I && foc_reg[2]) |=> LOOP_CFG_O.foc_gain_half == 4'h1;
  endproperty
  a_foc_post: assert property (p_foc_post) else $error("post-sync freq gain wrong"); // [RL9]

  // [RL8] Pre-sync gain
  property p_foc_pre;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (!SYNC_FOUND_I && foc_reg[4:3] == 2'h3) |=> LOOP_CFG_O.foc_gain_half == 4'h8;
  endproperty
  a_foc_pre: assert property (p_foc_pre) else $error("pre-sync freq gain wrong"); // [RL8]

  // [RL13] Post-sync integral
  property p_ki_post;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (SYNC_FOUND_I && bs_reg[3]) |=> LOOP_CFG_O.ki_gain_half == 4'h1;
  endproperty
  a_ki_post: assert property (p_ki_post) else $error("post-sync integral gain wrong"); // [RL13]

  // [RL15] Rate limit follows
  property p_rate_lim;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !SYS_RST_I |=> LOOP_CFG_O.rate_limit == $past(bs_reg[1:0]);
  endproperty
  a_rate_lim: assert property (p_rate_lim) else $error("rate limit mismatch"); // [RL15]

  // [RL10] Frequency limit follows
  property p_freq_offset_saturation;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !SYS_RST_I |=> LOOP_CFG_O.freq_offset_saturation == $past(foc_reg[1:0]);
  endproperty
  a_freq_offset_saturation: assert property (p_freq_offset_saturation) else $error("frequency limit mismatch"); // [RL10]

  // [RL11] Pre-sync integral base
  property p_ki_pre;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (!SYNC_FOUND_I && bs_reg[7:6] == 2'h0) |=> LOOP_CFG_O.ki_gain_half == 4'h2;
  endproperty
  a_ki_pre: assert property (p_ki_pre) else $error("pre-sync integral gain wrong"); // [RL11]

  // [RL12] Pre-sync proportional double
  property p_kp_pre;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (!SYNC_FOUND_I && bs_reg[5:4] == 2'h1) |=> LOOP_CFG_O.kp_gain_half == 4'h4;
  endproperty
  a_kp_pre: assert property (p_kp_pre) else $error("pre-sync proportional gain wrong"); // [RL12]

  // [RL14] Post-sync proportional gain
  property p_kp_post;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (SYNC_FOUND_I && bs_reg[2]) |=> LOOP_CFG_O.kp_gain_half == 4'h2;
  endproperty
  a_kp_post: assert property (p_kp_post) else $error("post-sync proportional gain wrong"); // [RL14]

  // [RL16] Masked frequency write
  property p_foc_mask;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (REG_WR_I && REG_ADDR_I == rcdl_pkg::ADDR_FOC_CFG) |=> foc_reg == {1'b0, $past(REG_WDATA_I[6:0])};
  endproperty
  a_foc_mask: assert property (p_foc_mask) else $error("frequency register write wrong"); // [RL16]
endmodule
`default_nettype wire

//--- verification/test_rcdl_top.sv
// Self-checking testbench for the calibration policy and loop configuration bank
`timescale 1ns/100ps
`default_nettype none
module test_rcdl_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [2:0] ev = 3'h0;
  logic cs = 1'b0;
  logic sync = 1'b0;
  logic cal;
  logic [1:0] cnt;
  rcdl_pkg::rcdl_loop_s cfg;
  int errors = 0;
  int checked = 0;

  // Clock, 8 ns period
  always #4 clk = ~clk;

  rcdl_top i_dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .IDLE_TO_ACTIVE_I(ev[1]), .AUTO_RETURN_IDLE_I(ev[2]),
    .MANUAL_CALIBRATE_STROBE_I(ev[0]), .CARRIER_SENSE_I(cs), .SYNC_FOUND_I(sync), .CAL_START_O(cal),
    .RETURN_COUNT_O(cnt), .LOOP_CFG_O(cfg));

  // Compare and count
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Read data compare
  task automatic chk_rdata(input logic [7:0] exp);
    chk({12'h000, rdata}, {12'h000, exp}, "read data");
  endtask

  // Calibrate start compare
  task automatic chk_cal(input logic exp);
    chk({19'h0, cal}, {19'h0, exp}, "cal start");
  endtask

  // Return count compare
  task automatic chk_cnt(input logic [1:0] exp);
    chk({18'h0, cnt}, {18'h0, exp}, "return count");
  endtask

  // Loop selection compare
  task automatic chk_cfg(input rcdl_pkg::rcdl_loop_s exp);
    chk(20'(cfg), 20'(exp), "loop config");
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One-cycle register write
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read, data must stand one cycle only
  task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_rdata(exp);
    @(posedge clk);
    #1;
    chk_rdata(8'h00);
  endtask

  // Radio event pulse, calibrate start expected in next cycle only
  task automatic pulse(input int idx, input logic exp);
    @(posedge clk);
    ev[idx] <= 1'b1;
    @(posedge clk);
    ev[idx] <= 1'b0;
    #1;
    chk_cal(exp);
    @(posedge clk);
    #1;
    chk_cal(1'b0);
  endtask

  // Expected loop selections in half units of the base gains
  function automatic rcdl_pkg::rcdl_loop_s exp_cfg(input logic [7:0] f, input logic [7:0] b, input logic s,
    input logic frz);
    rcdl_pkg::rcdl_loop_s e;
    e.freeze = frz;
    e.foc_gain_half = (s && f[2]) ? 4'h1 : 4'(2 * (f[4:3] + 1));
    e.freq_offset_saturation = f[1:0];
    e.ki_gain_half = (s && b[3]) ? 4'h1 : 4'(2 * (b[7:6] + 1));
    e.kp_gain_half = (s && b[2]) ? 4'h2 : 4'(2 * (b[5:4] + 1));
    e.rate_limit = b[1:0];
    return e;
  endfunction

  // Program both loop registers and compare the selections
  task automatic cfg_chk(input logic [7:0] f, input logic [7:0] b, input logic frz);
    reg_wr(rcdl_pkg::ADDR_FOC_CFG, f);
    reg_wr(rcdl_pkg::ADDR_BS_CFG, b);
    repeat (4) @(posedge clk);
    #1;
    chk_cfg(exp_cfg(f, b, sync, frz));
  endtask

  // Reset contents, masked bits and unmapped addresses
  task automatic t_regs();
    reg_rd(rcdl_pkg::ADDR_CAL_POLICY, 8'h04);
    reg_rd(rcdl_pkg::ADDR_FOC_CFG, 8'h76);
    reg_rd(rcdl_pkg::ADDR_BS_CFG, 8'h6C);
    chk_cfg(exp_cfg(8'h76, 8'h6C, 1'b0, 1'b1));
    reg_wr(rcdl_pkg::ADDR_CAL_POLICY, 8'hC4);
    reg_rd(rcdl_pkg::ADDR_CAL_POLICY, 8'h04);
    reg_wr(rcdl_pkg::ADDR_FOC_CFG, 8'hBF);
    reg_rd(rcdl_pkg::ADDR_FOC_CFG, 8'h3F);
    reg_wr(rcdl_pkg::ADDR_BS_CFG, 8'hFF);
    reg_rd(rcdl_pkg::ADDR_BS_CFG, 8'hFF);
    reg_wr(16'hDF17, 8'h55);
    reg_rd(16'hDF17, 8'h00);
    reg_rd(16'hDF13, 8'h00);
    reg_rd(rcdl_pkg::ADDR_BS_CFG, 8'hFF);
  endtask

  // Every calibration mode against every event kind
  task automatic t_cal();
    for (int m = 0; m < 3; m++) begin
      reg_wr(rcdl_pkg::ADDR_CAL_POLICY, 8'h04 | 8'(m << 4));
      pulse(0, 1'b1);
      pulse(1, m == 1);
      pulse(2, m == 2);
      chk_cnt(2'h0);
    end
    reg_wr(rcdl_pkg::ADDR_CAL_POLICY, 8'h34);
    reg_rd(rcdl_pkg::ADDR_CAL_POLICY, 8'h34);
    pulse(1, 1'b0);
    for (int n = 1; n <= 8; n++) begin
      pulse(2, n % 4 == 0);
      chk_cnt(2'(n % 4));
    end
    pulse(0, 1'b1);
  endtask

  // Every gain and limit code, before and after sync
  task automatic t_gain();
    logic [7:0] f;
    logic [7:0] b;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      sync <= s[0];
      for (int i = 0; i < 4; i++) begin
        f = 8'((i << 3) | (3 - i));
        b = 8'((i << 6) | ((3 - i) << 4) | i);
        cfg_chk(f, b, 1'b0);
        cfg_chk(f | 8'h04, b | 8'(4 << (i % 2)), 1'b0);
      end
    end
    @(posedge clk);
    sync <= 1'b0;
  endtask

  // Carrier-sense gating of both loops
  task automatic t_gate();
    cfg_chk(8'h36, 8'h6C, 1'b1);
    @(posedge clk);
    cs <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk_cfg(exp_cfg(8'h36, 8'h6C, sync, 1'b0));
    @(posedge clk);
    cs <= 1'b0;
    cfg_chk(8'h16, 8'h6C, 1'b0);
    cfg_chk(8'h36, 8'h6C, 1'b1);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_cal();
    t_gain();
    t_gate();
    finish_test();
  end

  // Watchdog
  initial begin
    #200000;
    errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
